// ---- tbdf_pkg.sv ----
// shared constants and carrier types for the touch detect filter
package tbdf_pkg;
  localparam int         NUM_SENSORS  = 2;
  localparam int         RAW_W        = 16;
  localparam int         REG_W        = 8;
  // register offsets
  localparam logic [7:0] ADDR_NOISE   = 8'h4e;
  localparam logic [7:0] ADDR_HYST    = 8'h52;
  localparam logic [7:0] ADDR_DEB     = 8'h53;
  localparam logic [7:0] ADDR_NNT     = 8'h54;
  localparam logic [7:0] ADDR_LBR     = 8'h55;
  localparam logic [7:0] ADDR_FILT    = 8'h56;
  localparam logic [7:0] ADDR_FT0     = 8'h66;
  localparam logic [7:0] ADDR_FT1     = 8'h67;
  // reset values
  localparam logic [7:0] RST_NOISE    = 8'h28;
  localparam logic [7:0] RST_COMMON   = 8'h0a;
  localparam logic [7:0] RST_FT       = 8'h64;
  // filter control field positions and reset bits
  localparam int         FILT_FORCE_BASELINE_RESET   = 7;
  localparam int         FILT_DROP    = 5;
  localparam int         FILT_AVG_EN  = 4;
  localparam int         FILT_ORD_LO  = 0;
  localparam logic [7:0] FILT_RW_MASK = 8'h33;
  localparam logic [7:0] RST_FILT     = 8'h20;

  typedef struct packed {
    logic             sensor;
    logic [RAW_W-1:0] raw;
  } tbdf_sample_t;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tbdf_reg_req_t;

  typedef enum logic [1:0] {
    ST_INACTIVE = 2'b01,
    ST_ACTIVE   = 2'b10
  } tbdf_state_t;
endpackage

// ---- tbdf_top.sv ----
// touch detection, baseline tracking and raw-count filtering
`timescale 1ns/1ps

module tbdf_top (
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  input  wire tbdf_pkg::tbdf_reg_req_t         reg_req,
  output logic [7:0]                           reg_rd_data,
  input  wire logic                            sample_valid,
  input  wire tbdf_pkg::tbdf_sample_t          sample_in,
  input  wire logic                            bus_busy,
  output logic [tbdf_pkg::NUM_SENSORS-1:0]     sensor_active,
  output logic [tbdf_pkg::RAW_W-1:0]           baseline_0,
  output logic [tbdf_pkg::RAW_W-1:0]           baseline_1
);
  import tbdf_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  noise_q, hyst_q, deb_q, nnt_q, lbr_q, filt_q;
  logic [7:0]  ft_q [NUM_SENSORS];
  logic        force_baseline_reset_pulse;

  function automatic logic hit(input logic [7:0] a);
    return reg_req.wr_en && (reg_req.addr == a);
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      noise_q  <= RST_NOISE;
      hyst_q   <= RST_COMMON;
      deb_q    <= RST_COMMON;
      nnt_q    <= RST_COMMON;
      lbr_q    <= RST_COMMON;
      filt_q   <= RST_FILT;
      ft_q[0]  <= RST_FT;
      ft_q[1]  <= RST_FT;
    end else begin
      if (hit(ADDR_NOISE)) noise_q <= reg_req.wdata;
      if (hit(ADDR_HYST))  hyst_q  <= reg_req.wdata;
      if (hit(ADDR_DEB))   deb_q   <= reg_req.wdata;
      if (hit(ADDR_NNT))   nnt_q   <= reg_req.wdata;
      if (hit(ADDR_LBR))   lbr_q   <= reg_req.wdata;
      if (hit(ADDR_FT0))   ft_q[0] <= reg_req.wdata;
      if (hit(ADDR_FT1))   ft_q[1] <= reg_req.wdata;
      // force bit stands for one cycle then clears itself
      if (hit(ADDR_FILT)) begin
        filt_q <= reg_req.wdata & (FILT_RW_MASK | 8'h80);
      end else begin
        filt_q[FILT_FORCE_BASELINE_RESET] <= 1'b0;
      end
    end
  end

  assign force_baseline_reset_pulse = filt_q[FILT_FORCE_BASELINE_RESET];

  // registered read data; reserved bits read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_data <= 8'h00;
    end else begin
      case (reg_req.addr)
        ADDR_NOISE: reg_rd_data <= noise_q;
        ADDR_HYST:  reg_rd_data <= hyst_q;
        ADDR_DEB:   reg_rd_data <= deb_q;
        ADDR_NNT:   reg_rd_data <= nnt_q;
        ADDR_LBR:   reg_rd_data <= lbr_q;
        ADDR_FILT:  reg_rd_data <= filt_q;
        ADDR_FT0:   reg_rd_data <= ft_q[0];
        ADDR_FT1:   reg_rd_data <= ft_q[1];
        default:    reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus-activity sample drop
  // ----------------------------------------------------------------
  // traffic is remembered over the whole interval since the last sample
  logic bus_seen_q;
  logic accept;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_seen_q <= 1'b0;
    end else if (sample_valid) begin
      bus_seen_q <= bus_busy;
    end else if (bus_busy) begin
      bus_seen_q <= 1'b1;
    end
  end

  assign accept = sample_valid &&
                  !(filt_q[FILT_DROP] && (bus_seen_q || bus_busy));

  // ----------------------------------------------------------------
  // block averaging
  // ----------------------------------------------------------------
  // block average, not sliding: output rate drops by a factor of 2 << order, but no
  // per-sensor sample memory is needed
  logic [RAW_W+3:0] acc_q [NUM_SENSORS];
  logic [3:0]       avg_cnt_q [NUM_SENSORS];
  logic [1:0]       order;
  logic [3:0]       last_idx;
  logic [RAW_W+3:0] acc_sum;
  logic             proc_valid;
  logic [RAW_W-1:0] proc_raw;
  logic             s;

  assign s        = sample_in.sensor;
  assign order    = filt_q[FILT_ORD_LO +: 2];
  assign last_idx = 4'((5'd2 << order) - 5'd1);
  assign acc_sum  = acc_q[s] + {4'h0, sample_in.raw};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
        acc_q[i]     <= '0;
        avg_cnt_q[i] <= 4'h0;
      end
    end else if (!filt_q[FILT_AVG_EN]) begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
        acc_q[i]     <= '0;
        avg_cnt_q[i] <= 4'h0;
      end
    end else if (accept) begin
      if (avg_cnt_q[s] >= last_idx) begin
        acc_q[s]     <= '0;
        avg_cnt_q[s] <= 4'h0;
      end else begin
        acc_q[s]     <= acc_sum;
        avg_cnt_q[s] <= avg_cnt_q[s] + 4'h1;
      end
    end
  end

  always_comb begin
    proc_valid = accept;
    proc_raw   = sample_in.raw;
    if (filt_q[FILT_AVG_EN]) begin
      proc_valid = accept && (avg_cnt_q[s] >= last_idx);
      // three-bit shift amount: order 3 needs a shift of four
      proc_raw   = RAW_W'(acc_sum >> (3'(order) + 3'd1));
    end
  end

  // ----------------------------------------------------------------
  // baseline tracking and touch detection
  // ----------------------------------------------------------------
  logic [RAW_W-1:0] base_q [NUM_SENSORS];
  logic             base_init_q [NUM_SENSORS];
  logic [7:0]       deb_cnt_q [NUM_SENSORS];
  logic [7:0]       low_cnt_q [NUM_SENSORS];
  tbdf_state_t      state_q [NUM_SENSORS];
  logic signed [RAW_W:0] diff;
  logic signed [RAW_W:0] on_level, off_level, pos_lim, neg_lim;
  logic             above_on, below_off, too_low, too_high;

  always_comb begin
    diff      = $signed({1'b0, proc_raw})
              - $signed({1'b0, base_q[s]});
    on_level  = (RAW_W+1)'(ft_q[s]) + (RAW_W+1)'(hyst_q);
    off_level = (RAW_W+1)'(ft_q[s]) - (RAW_W+1)'(hyst_q);
    pos_lim   = (RAW_W+1)'(noise_q);
    neg_lim   = -((RAW_W+1)'(nnt_q));
    above_on  = diff > on_level;
    below_off = diff < off_level;
    too_low   = diff < neg_lim;
    too_high  = diff > pos_lim;
  end

  // baselines and low-sample counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
        base_q[i]      <= '0;
        base_init_q[i] <= 1'b0;
        low_cnt_q[i]   <= 8'h00;
      end
    end else begin
      if (proc_valid) begin
        if (!base_init_q[s]) begin
          base_q[s]      <= proc_raw;
          base_init_q[s] <= 1'b1;
          low_cnt_q[s]   <= 8'h00;
        end else if (too_low) begin
          // baseline frozen until enough low samples in a row
          if (low_cnt_q[s] + 8'h01 >= lbr_q) begin
            base_q[s]    <= proc_raw;
            low_cnt_q[s] <= 8'h00;
          end else begin
            low_cnt_q[s] <= low_cnt_q[s] + 8'h01;
          end
        end else begin
          low_cnt_q[s] <= 8'h00;
          if (diff > 0 && !too_high) begin
            base_q[s] <= base_q[s] + 1'b1;
          end else if (diff < 0) begin
            base_q[s] <= base_q[s] - 1'b1;
          end
        end
      end
      // forced reset: next sample of each sensor reloads its baseline
      if (force_baseline_reset_pulse) begin
        for (int i = 0; i < NUM_SENSORS; i++) begin
          base_init_q[i] <= 1'b0;
        end
      end
    end
  end

  // activation state and debounce
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
        state_q[i]   <= ST_INACTIVE;
        deb_cnt_q[i] <= 8'h00;
      end
    end else if (proc_valid && base_init_q[s]) begin
      case (state_q[s])
        ST_INACTIVE: begin
          if (above_on) begin
            // a setting of zero behaves like one
            if (deb_cnt_q[s] + 8'h01 >= deb_q) begin
              state_q[s]   <= ST_ACTIVE;
              deb_cnt_q[s] <= 8'h00;
            end else begin
              deb_cnt_q[s] <= deb_cnt_q[s] + 8'h01;
            end
          end else begin
            deb_cnt_q[s] <= 8'h00;
          end
        end
        ST_ACTIVE: begin
          deb_cnt_q[s] <= 8'h00;
          if (below_off) begin
            state_q[s] <= ST_INACTIVE;
          end
        end
        default: begin
          state_q[s]   <= ST_INACTIVE;
          deb_cnt_q[s] <= 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SENSORS; i++) begin
      sensor_active[i] = (state_q[i] == ST_ACTIVE);
    end
  end

  assign baseline_0 = base_q[0];
  assign baseline_1 = base_q[1];
endmodule

// ---- tbdf_properties.sv ----
// port assertions for the touch detect filter
`timescale 1ns/1ps
module tbdf_properties (
  input wire logic                          clock,
  input wire logic                          arst_n,
  input wire tbdf_pkg::tbdf_reg_req_t       reg_req,
  input wire logic [7:0]                    reg_rd_data,
  input wire logic                          sample_valid,
  input wire tbdf_pkg::tbdf_sample_t        sample_in,
  input wire logic                          bus_busy,
  input wire logic [tbdf_pkg::NUM_SENSORS-1:0] sensor_active,
  input wire logic [tbdf_pkg::RAW_W-1:0]    baseline_0,
  input wire logic [tbdf_pkg::RAW_W-1:0]    baseline_1
);
  import tbdf_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic mapped;
  assign mapped = reg_req.addr inside {ADDR_NOISE, [ADDR_HYST:ADDR_FILT],
                                       ADDR_FT0, ADDR_FT1};
  // --------------------------------------------------------------
  // activation state and baselines move only on a sample of their own sensor
  // --------------------------------------------------------------
  a_act0_cause: assert property (
    $changed(sensor_active[0]) |-> $past(sample_valid && !sample_in.sensor))
    else $error("active 0 moved without its sample");
  a_act1_cause: assert property (
    $changed(sensor_active[1]) |-> $past(sample_valid && sample_in.sensor))
    else $error("active 1 moved without its sample");
  a_base_hold: assert property (
    !$past(sample_valid) |-> $stable(baseline_0) && $stable(baseline_1))
    else $error("baseline moved without a sample");
  a_base_other: assert property (
    sample_valid |=> ($past(sample_in.sensor) ? $stable(baseline_0)
                                               : $stable(baseline_1)))
    else $error("baseline of other sensor moved");
  // --------------------------------------------------------------
  // register reads
  // --------------------------------------------------------------
  a_unmapped_zero: assert property (
    !mapped |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
  a_filt_resv: assert property (
    reg_req.addr == ADDR_FILT |=> (reg_rd_data & 8'h4c) == 8'h00)
    else $error("reserved filter bits set");
  a_wr_readback: assert property (
    reg_req.wr_en && reg_req.addr inside {[ADDR_HYST:ADDR_LBR]} ##1
    !reg_req.wr_en && reg_req.addr == $past(reg_req.addr)
    |=> reg_rd_data == $past(reg_req.wdata, 2)) else $error("readback");
  a_force_baseline_reset_clear: assert property (
    reg_req.wr_en && reg_req.addr == ADDR_FILT ##1 !reg_req.wr_en ##1
    !reg_req.wr_en && reg_req.addr == ADDR_FILT |=> !reg_rd_data[FILT_FORCE_BASELINE_RESET])
    else $error("force reset bit stuck");
  c_act0: cover property ($rose(sensor_active[0]));
  c_act1: cover property ($rose(sensor_active[1]));
  c_busy: cover property (sample_valid && bus_busy);
endmodule

// ---- tbdf_host.sv ----
// host model issuing register writes and read selects
`timescale 1ns/1ps
module tbdf_host (
  input wire logic                 clock,
  output tbdf_pkg::tbdf_reg_req_t  reg_req
);
  import tbdf_pkg::*;
  initial reg_req = '0;
  // strobe held for exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req = '{1'b1, a, d};
    @(negedge clock);
    reg_req.wr_en = 1'b0;
  endtask
  task automatic sel(input logic [7:0] a);
    @(negedge clock);
    reg_req = '{1'b0, a, 8'h00};
  endtask
endmodule

// ---- tbdf_top_tb.sv ----
// self-checking bench for the touch detect filter
`timescale 1ns/1ps
module tbdf_top_tb;
  import tbdf_pkg::*;
  logic clock, arst_n, sample_valid, bus_busy, look;
  tbdf_reg_req_t reg_req;
  tbdf_sample_t sample_in;
  logic [7:0] reg_rd_data;
  logic [NUM_SENSORS-1:0] sensor_active;
  logic [RAW_W-1:0] baseline_0, baseline_1, b, o;
  logic [17:0] q[$], e;
  logic [15:0] rv[8] = '{16'h520a, 16'h530a, 16'h540a, 16'h550a,
                         16'h5620, 16'h4e28, 16'h6664, 16'h0100};
  int bad_count, comparisons, cycles;
  int seed = 32'h9ff36b46;
  tbdf_host u_host (.clock(clock), .reg_req(reg_req));
  tbdf_top u_dut (.clock(clock), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .sample_valid(sample_valid),
    .sample_in(sample_in), .bus_busy(bus_busy),
    .sensor_active(sensor_active), .baseline_0(baseline_0),
    .baseline_1(baseline_1));
  always #5 clock = ~clock;
  // --------------------------------------------------------------
  // drivers note the expectation, the monitor compares
  // --------------------------------------------------------------
  task automatic put(input logic [1:0] k, input logic [15:0] v);
    q.push_back({k, v});
    look = 1'b1;
    @(negedge clock);
    look = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    u_host.sel(a);
    put(2'd0, {8'h00, x});
  endtask
  task automatic see(input logic [1:0] k, input logic [15:0] v);
    @(negedge clock);
    put(k, v);
  endtask
  task automatic smp(input logic s, input logic [15:0] r);
    @(negedge clock);
    sample_valid = 1'b1;
    sample_in = '{s, r};
    @(negedge clock);
    sample_valid = 1'b0;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    #1;
    if (look) begin
      e = q.pop_front();
      case (e[17:16])
        2'd0: o = {8'h00, reg_rd_data};
        2'd1: o = {14'h0000, sensor_active};
        2'd2: o = baseline_0;
        default: o = baseline_1;
      endcase
      comparisons++;
      if (o !== e[15:0]) begin
        bad_count++;
        $display("ERROR %0t kind %0d got %h want %h", $time, e[17:16], o,
                 e[15:0]);
      end
    end
  end
  // hang guard, the whole run is well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      results;
    end
  end
  initial begin
    {clock, arst_n, sample_valid, bus_busy, look} = '0;
    sample_in = '0;
    repeat (12) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    u_host.wr(ADDR_FILT, 8'hff);
    rd(ADDR_FILT, 8'h33);
    u_host.wr(ADDR_FILT, 8'h00);
    u_host.wr(ADDR_HYST, 8'h0f);
    u_host.wr(ADDR_LBR, 8'h03);
    rd(ADDR_HYST, 8'h0f);
    $display("test registers done");
    b = 16'd1000;
    smp(0, b); see(2, b);
    smp(0, b + 5); b++; see(2, b);
    smp(0, b - 5); b--; see(2, b);
    smp(0, b + 41); see(2, b);
    repeat (2) begin smp(0, b - 11); see(2, b); end
    smp(0, b - 1); b--; see(2, b);
    repeat (2) smp(0, b - 20);
    see(2, b);
    smp(0, b - 20); b -= 20; see(2, b);
    $display("test tracking done");
    u_host.wr(ADDR_FILT, 8'h20);
    @(negedge clock) bus_busy = 1'b1;
    smp(0, 16'($random(seed))); see(2, b);
    u_host.wr(ADDR_FILT, 8'h00);
    smp(0, b + 3); b++; see(2, b);
    @(negedge clock) bus_busy = 1'b0;
    for (int k = 0; k < 4; k++) begin
      u_host.wr(ADDR_FILT, 8'h10 | 8'(k));
      repeat ((2 << k) - 1) smp(0, b + 3);
      see(2, b);
      smp(0, b + 3); b++; see(2, b);
    end
    u_host.wr(ADDR_FILT, 8'h00);
    $display("test filters done");
    u_host.wr(ADDR_DEB, 8'h03);
    repeat (2) smp(0, b + 116);
    smp(0, b + 115);
    repeat (2) smp(0, b + 116);
    see(1, 16'h0000);
    smp(0, b + 116); see(1, 16'h0001);
    smp(0, b + 85); see(1, 16'h0001);
    smp(0, b + 84); see(1, 16'h0000);
    u_host.wr(ADDR_DEB, 8'h01);
    u_host.wr(ADDR_FT1, 8'h32);
    smp(1, 16'd500);
    smp(1, 16'd566);
    see(1, 16'h0002);
    $display("test detection done");
    u_host.wr(ADDR_FILT, 8'h80);
    smp(0, 16'd3000); see(2, 16'd3000);
    smp(1, 16'd2000); see(3, 16'd2000);
    $display("test force reset done");
    results;
  end
endmodule
bind tbdf_top tbdf_properties u_props (.clock(clock), .arst_n(arst_n),
  .reg_req(reg_req), .reg_rd_data(reg_rd_data),
  .sample_valid(sample_valid), .sample_in(sample_in), .bus_busy(bus_busy),
  .sensor_active(sensor_active), .baseline_0(baseline_0),
  .baseline_1(baseline_1));
